// *** logic/card_cmd_pkg.sv ***
// constants, types and the crc step of the card memory command layer
// assumes a framer on the link clock that hands over decrypted bytes
//
// Notes on behaviour
// - read 30h plus block returns sixteen bytes
// - block number is one byte, 00h to 3Fh
// - frames and data replies end in two-byte crc
// - read reply no sooner than 71 us
// - write A0h, then sixteen bytes stored
// - write is two exchanges, each answered
// - write replies no sooner than 71 us
// - C1h adds operand into value register
// - C0h subtracts operand into value register
// - C2h copies source value unchanged
// - operand is four bytes, two's complement
// - operand part gets no answer at all
// - value command replies no sooner than 71 us
// - only transfer commits value to memory
// - B0h writes value register into block
// - transfer reply no sooner than 71 us
// - code Ah acknowledges, all others reject
// - commands need authenticated sector
package card_cmd_pkg;

  // ----------------------------------------------------------------
  // command codes and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_READ     = 8'h30;
  localparam logic [7:0]  CMD_WRITE    = 8'ha0;
  localparam logic [7:0]  CMD_DEC      = 8'hc0;
  localparam logic [7:0]  CMD_INC      = 8'hc1;
  localparam logic [7:0]  CMD_RESTORE  = 8'hc2;
  localparam logic [7:0]  CMD_TRANSFER = 8'hb0;
  localparam logic [7:0]  BLOCK_LAST   = 8'h3f;  // highest block
  localparam int          BLOCK_BYTES  = 16;
  localparam int          BLOCKS       = 64;
  localparam int          FRAME_MAX    = 18;     // data plus crc
  localparam logic [4:0]  LEN_CMD      = 5'h04;  // cmd, block, crc
  localparam logic [4:0]  LEN_OPERAND  = 5'h06;  // operand, crc
  localparam logic [4:0]  LEN_DATA     = 5'h12;  // block, crc
  localparam logic [4:0]  LEN_CODE     = 5'h01;  // one nibble
  localparam logic [3:0]  CODE_ACK     = 4'ha;
  localparam logic [3:0]  CODE_NAK     = 4'h4;
  localparam logic [15:0] CRC_INIT     = 16'h6363;
  localparam logic [15:0] CRC_POLY     = 16'h8408; // reflected
  localparam logic [15:0] CRC_RESIDUE  = 16'h0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REPLY_MIN_US  = 71;
  localparam int REPLY_MIN_CYC =
    (REPLY_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_GUARD = 3'b010,
    ST_SEND  = 3'b100
  } state_e;

  typedef enum logic [2:0] {
    PEND_NONE  = 3'b001,
    PEND_WRITE = 3'b010,
    PEND_VALUE = 3'b100
  } pend_e;

  // one byte through the crc, low bit first
  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0]  b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// *** logic/card_link_if.sv ***
// frame and reply buffers shared by the two clock domains
// assumes toggle handshakes guard every buffer while it is read
`timescale 1ns/1ps
`default_nettype none
interface card_link_if;
  logic [7:0] rx_buf [card_cmd_pkg::FRAME_MAX]; // received frame
  logic [4:0] rx_len;                           // its length
  logic       rx_req_tgl;                       // frame ready
  logic       rx_ack_tgl;                       // frame taken
  logic [7:0] tx_buf [card_cmd_pkg::FRAME_MAX]; // reply bytes
  logic [4:0] tx_len;                           // reply length
  logic       tx_nibble;                        // reply is a code
  logic       tx_req_tgl;                       // reply ready
  logic       tx_done_tgl;                      // reply sent

  modport link (output rx_buf, rx_len, rx_req_tgl, tx_done_tgl,
                input  rx_ack_tgl, tx_buf, tx_len, tx_nibble,
                       tx_req_tgl);
  modport core (input  rx_buf, rx_len, rx_req_tgl, tx_done_tgl,
                output rx_ack_tgl, tx_buf, tx_len, tx_nibble,
                       tx_req_tgl);
endinterface
`default_nettype wire

// *** logic/card_link_port.sv ***
// link side: gathers frame bytes and plays out replies
// assumes the framer runs on link_clk, which the carrier keeps running
`timescale 1ns/1ps
`default_nettype none
module card_link_port (
  input  wire logic       link_clk,
  input  wire logic       reset,
  card_link_if.link       xf,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_end,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_nibble,
  output logic            tx_last
);

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic       rst_s1, rst_s2;   // reset into link domain
  logic       ack_s1, ack_s2;   // frame taken
  logic       req_s1, req_s2;   // reply ready
  logic [4:0] cnt_reg;          // bytes seen in this frame
  logic [4:0] idx_reg;          // next reply byte
  logic       seen_reg;         // last reply request served
  logic       busy;             // frame not yet taken

  // two stages for each crossing level
  always_ff @(posedge link_clk) begin
    rst_s1 <= reset;
    rst_s2 <= rst_s1;
    ack_s1 <= xf.rx_ack_tgl;
    ack_s2 <= ack_s1;
    req_s1 <= xf.tx_req_tgl;
    req_s2 <= req_s1;
  end

  assign busy = xf.rx_req_tgl != ack_s2;

  // ----------------------------------------------------------------
  // receive
  // ----------------------------------------------------------------
  // count bytes, saturating one past a full frame to mark overlength
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      cnt_reg       <= 5'h00;
      xf.rx_len     <= 5'h00;
      xf.rx_req_tgl <= 1'b0;
    end else if (rx_end) begin
      cnt_reg <= 5'h00;
      // frames that arrive while the core is busy are dropped
      if (!busy) begin
        xf.rx_len     <= cnt_reg;
        xf.rx_req_tgl <= ~xf.rx_req_tgl;
      end
    end else if (rx_valid && !busy && cnt_reg <= card_cmd_pkg::LEN_DATA) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  // store bytes while the buffer is ours
  always_ff @(posedge link_clk) begin
    if (rx_valid && !rx_end && !busy && cnt_reg < card_cmd_pkg::LEN_DATA) begin
      xf.rx_buf[cnt_reg] <= rx_data;
    end
  end

  // ----------------------------------------------------------------
  // transmit
  // ----------------------------------------------------------------
  // one byte per accepted beat, done toggles after the last
  always_ff @(posedge link_clk) begin
    if (rst_s2) begin
      tx_valid       <= 1'b0;
      tx_data        <= 8'h00;
      tx_nibble      <= 1'b0;
      tx_last        <= 1'b0;
      idx_reg        <= 5'h00;
      seen_reg       <= 1'b0;
      xf.tx_done_tgl <= 1'b0;
    end else if (!tx_valid) begin
      // a new reply request starts play-out
      if (req_s2 != seen_reg) begin
        seen_reg  <= req_s2;
        tx_valid  <= 1'b1;
        tx_data   <= xf.tx_buf[0];
        tx_nibble <= xf.tx_nibble;
        tx_last   <= xf.tx_len == 5'h01;
        idx_reg   <= 5'h01;
      end
    end else if (tx_ready) begin
      if (tx_last) begin
        tx_valid       <= 1'b0;
        tx_last        <= 1'b0;
        xf.tx_done_tgl <= ~xf.tx_done_tgl;
      end else begin
        tx_data <= xf.tx_buf[idx_reg];
        tx_last <= idx_reg + 5'h01 == xf.tx_len;
        idx_reg <= idx_reg + 5'h01;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/card_cmd_core.sv ***
// memory command interpreter of a proximity card
// assumes decrypted, framed bytes on link_clk and an authentication status
// from logic on clk
`timescale 1ns/1ps
`default_nettype none
module card_cmd_core #(
  parameter int GUARD_CYC = card_cmd_pkg::REPLY_MIN_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       link_clk,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_end,
  input  wire logic       tx_ready,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  output logic            tx_nibble,
  output logic            tx_last,
  input  wire logic       auth_valid,
  input  wire logic [3:0] auth_sector
);

  // ----------------------------------------------------------------
  // link port
  // ----------------------------------------------------------------
  card_link_if xf ();

  card_link_port u_link (
    .link_clk  (link_clk),
    .reset     (reset),
    .xf        (xf.link),
    .rx_valid  (rx_valid),
    .rx_data   (rx_data),
    .rx_end    (rx_end),
    .tx_ready  (tx_ready),
    .tx_valid  (tx_valid),
    .tx_data   (tx_data),
    .tx_nibble (tx_nibble),
    .tx_last   (tx_last)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [127:0]         mem [card_cmd_pkg::BLOCKS]; // block store
  card_cmd_pkg::state_e state_reg;    // reply sequencing
  card_cmd_pkg::pend_e  pend_reg;     // awaited second part
  logic [7:0]           pend_op_reg;  // command of first part
  logic [5:0]           pend_blk_reg; // block of first part
  logic [31:0]          value_reg;    // volatile value
  logic [15:0]          guard_reg;    // reply delay count
  logic                 rx_s1, rx_s2; // frame ready sync
  logic                 done_s1;      // reply sent sync
  logic                 done_s2;
  logic                 rx_seen;      // last frame taken
  logic                 done_seen;    // last reply finished

  // two stages for each crossing level
  always_ff @(posedge clk) begin
    rx_s1   <= xf.rx_req_tgl;
    rx_s2   <= rx_s1;
    done_s1 <= xf.tx_done_tgl;
    done_s2 <= done_s1;
  end

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  logic         new_frame;  // frame taken this cycle
  logic [15:0]  crc_c;      // running crc of the frame
  logic [15:0]  reply_crc;  // crc of the read data
  logic         crc_ok;     // frame crc checks
  logic [7:0]   f_cmd;      // command byte
  logic [7:0]   f_blk;      // block byte
  logic [5:0]   rd_addr;    // block read port address
  logic [127:0] rd_word;    // addressed block
  logic [127:0] f_data;     // sixteen data bytes
  logic [31:0]  f_opnd;     // operand, low byte first
  logic [31:0]  src_val;    // value held in source block
  logic         blk_ok;     // block in range
  logic         auth_ok;    // sector authenticated
  logic         is_cmd;     // well-formed first part
  logic         cmd_go;     // first part accepted
  logic         known;      // command acknowledged by a code
  logic         wr_go;      // write data part accepted
  logic         val_go;     // operand part accepted
  logic         xfer_go;    // transfer accepted
  logic         ack_now;    // reply is acknowledge

  assign new_frame = state_reg == card_cmd_pkg::ST_IDLE && rx_s2 != rx_seen;

  // crc over the whole frame leaves the residue when intact
  always_comb begin
    crc_c = card_cmd_pkg::CRC_INIT;
    for (int i = 0; i < card_cmd_pkg::FRAME_MAX; i++) begin
      if (5'(i) < xf.rx_len) begin
        crc_c = card_cmd_pkg::crc_step(crc_c, xf.rx_buf[i]);
      end
    end
    f_data = '0;
    for (int i = 0; i < card_cmd_pkg::BLOCK_BYTES; i++) begin
      f_data[8*i +: 8] = xf.rx_buf[i];
    end
  end

  // crc appended to a read reply
  always_comb begin
    reply_crc = card_cmd_pkg::CRC_INIT;
    for (int i = 0; i < card_cmd_pkg::BLOCK_BYTES; i++) begin
      reply_crc = card_cmd_pkg::crc_step(reply_crc, rd_word[8*i +: 8]);
    end
  end

  assign crc_ok  = crc_c == card_cmd_pkg::CRC_RESIDUE;
  assign f_cmd   = xf.rx_buf[0];
  assign f_blk   = xf.rx_buf[1];
  assign f_opnd  = {xf.rx_buf[3], xf.rx_buf[2], xf.rx_buf[1], xf.rx_buf[0]};
  assign rd_addr = pend_reg == card_cmd_pkg::PEND_NONE ? f_blk[5:0]
                                                       : pend_blk_reg;
  assign rd_word = mem[rd_addr];
  assign src_val = rd_word[31:0];
  assign blk_ok  = f_blk <= card_cmd_pkg::BLOCK_LAST;
  assign auth_ok = auth_valid && auth_sector == f_blk[5:2];
  assign is_cmd  = pend_reg == card_cmd_pkg::PEND_NONE &&
                   xf.rx_len == card_cmd_pkg::LEN_CMD && crc_ok;
  assign cmd_go  = is_cmd && blk_ok && auth_ok;
  assign known   = f_cmd == card_cmd_pkg::CMD_WRITE ||
                   f_cmd == card_cmd_pkg::CMD_INC ||
                   f_cmd == card_cmd_pkg::CMD_DEC ||
                   f_cmd == card_cmd_pkg::CMD_RESTORE ||
                   f_cmd == card_cmd_pkg::CMD_TRANSFER;
  assign wr_go   = pend_reg == card_cmd_pkg::PEND_WRITE &&
                   xf.rx_len == card_cmd_pkg::LEN_DATA && crc_ok;
  assign val_go  = pend_reg == card_cmd_pkg::PEND_VALUE &&
                   xf.rx_len == card_cmd_pkg::LEN_OPERAND && crc_ok;
  assign xfer_go = cmd_go && f_cmd == card_cmd_pkg::CMD_TRANSFER;
  assign ack_now = (cmd_go && known) || wr_go;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // take a frame, hold off the reply, then wait for it to leave
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= card_cmd_pkg::ST_IDLE;
      rx_seen       <= 1'b0;
      done_seen     <= 1'b0;
      guard_reg     <= 16'h0000;
      xf.rx_ack_tgl <= 1'b0;
      xf.tx_req_tgl <= 1'b0;
    end else begin
      unique case (state_reg)
        card_cmd_pkg::ST_IDLE: begin
          if (new_frame) begin
            rx_seen       <= rx_s2;
            xf.rx_ack_tgl <= rx_s2;
            guard_reg     <= 16'h0000;
            // the operand part is never answered
            if (pend_reg != card_cmd_pkg::PEND_VALUE) begin
              state_reg <= card_cmd_pkg::ST_GUARD;
            end
          end
        end
        card_cmd_pkg::ST_GUARD: begin
          // least reply delay for every command and part
          if (guard_reg == 16'(GUARD_CYC - 1)) begin
            xf.tx_req_tgl <= ~xf.tx_req_tgl;
            state_reg     <= card_cmd_pkg::ST_SEND;
          end else begin
            guard_reg <= guard_reg + 16'h0001;
          end
        end
        card_cmd_pkg::ST_SEND: begin
          if (done_s2 != done_seen) begin
            done_seen <= done_s2;
            state_reg <= card_cmd_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // pending second part; any frame ends it, no time limit applies
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_reg     <= card_cmd_pkg::PEND_NONE;
      pend_op_reg  <= 8'h00;
      pend_blk_reg <= 6'h00;
    end else if (new_frame) begin
      pend_reg <= card_cmd_pkg::PEND_NONE;
      if (cmd_go && f_cmd == card_cmd_pkg::CMD_WRITE) begin
        pend_reg     <= card_cmd_pkg::PEND_WRITE;
        pend_blk_reg <= f_blk[5:0];
      end else if (cmd_go && known && !xfer_go) begin
        pend_reg     <= card_cmd_pkg::PEND_VALUE;
        pend_op_reg  <= f_cmd;
        pend_blk_reg <= f_blk[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // reply build
  // ----------------------------------------------------------------
  // data reply for a read, otherwise a four-bit code
  always_ff @(posedge clk) begin
    if (reset) begin
      xf.tx_len    <= card_cmd_pkg::LEN_CODE;
      xf.tx_nibble <= 1'b1;
      for (int i = 0; i < card_cmd_pkg::FRAME_MAX; i++) begin
        xf.tx_buf[i] <= 8'h00;
      end
    end else if (new_frame) begin
      if (cmd_go && f_cmd == card_cmd_pkg::CMD_READ) begin
        for (int i = 0; i < card_cmd_pkg::BLOCK_BYTES; i++) begin
          xf.tx_buf[i] <= rd_word[8*i +: 8];
        end
        xf.tx_buf[16] <= reply_crc[7:0];
        xf.tx_buf[17] <= reply_crc[15:8];
        xf.tx_len     <= card_cmd_pkg::LEN_DATA;
        xf.tx_nibble  <= 1'b0;
      end else begin
        // range, auth, crc and unknown faults all reject, except in the operand part, which gets no reply
        xf.tx_buf[0] <= {4'h0, ack_now ? card_cmd_pkg::CODE_ACK
                                       : card_cmd_pkg::CODE_NAK};
        xf.tx_len    <= card_cmd_pkg::LEN_CODE;
        xf.tx_nibble <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // memory and value register
  // ----------------------------------------------------------------
  // block writes: write data part and transfer commit
  always_ff @(posedge clk) begin
    if (new_frame && wr_go) begin
      mem[pend_blk_reg] <= f_data;
    end
    if (new_frame && xfer_go) begin
      mem[f_blk[5:0]] <= {rd_word[127:32], value_reg};
    end
  end

  // value arithmetic wraps in two's complement; block untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      value_reg <= 32'h0000_0000;
    end else if (new_frame && val_go) begin
      if (pend_op_reg == card_cmd_pkg::CMD_INC) begin
        value_reg <= src_val + f_opnd;
      end else if (pend_op_reg == card_cmd_pkg::CMD_DEC) begin
        value_reg <= src_val - f_opnd;
      end else begin
        value_reg <= src_val;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] age_reg; // cycles since the last frame was taken

  // saturating age of the current exchange
  always_ff @(posedge clk) begin
    if (reset || new_frame) begin
      age_reg <= 16'h0000;
    end else if (age_reg != 16'hffff) begin
      age_reg <= age_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_reply_guard: assert property (
    $changed(xf.tx_req_tgl) |-> age_reg >= 16'(GUARD_CYC))
    else $error("reply requested before the least delay");

  a_read_reply: assert property (
    new_frame && cmd_go && f_cmd == card_cmd_pkg::CMD_READ |=>
      xf.tx_len == card_cmd_pkg::LEN_DATA && !xf.tx_nibble)
    else $error("read did not build a data reply");

  a_read_crc: assert property (
    new_frame && cmd_go && f_cmd == card_cmd_pkg::CMD_READ |=>
      {xf.tx_buf[17], xf.tx_buf[16]} == $past(reply_crc))
    else $error("read reply crc wrong");

  a_range_nak: assert property (
    new_frame && is_cmd && !blk_ok |=>
      xf.tx_nibble && xf.tx_buf[0][3:0] == card_cmd_pkg::CODE_NAK)
    else $error("out-of-range block not rejected");

  a_auth_nak: assert property (
    new_frame && is_cmd && !auth_ok |=>
      xf.tx_buf[0][3:0] != card_cmd_pkg::CODE_ACK)
    else $error("command without authentication accepted");

  a_operand_silent: assert property (
    new_frame && pend_reg == card_cmd_pkg::PEND_VALUE |=>
      $stable(xf.tx_req_tgl) [*8])
    else $error("operand part was answered");

  a_inc_sum: assert property (
    new_frame && val_go && pend_op_reg == card_cmd_pkg::CMD_INC |=>
      value_reg == $past(src_val) + $past(f_opnd))
    else $error("increment result wrong");

  a_dec_diff: assert property (
    new_frame && val_go && pend_op_reg == card_cmd_pkg::CMD_DEC |=>
      value_reg == $past(src_val) - $past(f_opnd))
    else $error("decrement result wrong");

  a_write_store: assert property (
    new_frame && wr_go |=>
      mem[$past(pend_blk_reg)] == $past(f_data) &&
      xf.tx_buf[0][3:0] == card_cmd_pkg::CODE_ACK)
    else $error("write data not stored or not acknowledged");

  a_xfer_commit: assert property (
    new_frame && xfer_go |=> mem[$past(rd_addr)][31:0] == $past(value_reg))
    else $error("transfer did not commit the value");

endmodule
`default_nettype wire

// *** bench/card_reader.sv ***
// reader model: sends frames and collects replies on the link clock
// assumes the bench calls its tasks, one exchange at a time
`timescale 1ns/1ps
`default_nettype none
module card_reader (
  input  wire logic       link_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_end,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_nibble,
  input  wire logic       tx_last
);
  bit         slow = 1'b0; // stall every other beat
  logic [7:0] rb [20];     // reply bytes
  logic       rnib;        // reply was a code
  int         rn;          // reply byte count
  time        te, tf;      // frame end, first reply byte
  initial rx_valid = 1'b0;
  initial rx_data = 8'h00;
  initial rx_end = 1'b0;
  initial tx_ready = 1'b0;
  // crc step, low bit first
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0]  b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  // frame then crc low byte first; bad spoils the crc
  task automatic send(input logic [7:0] f [18], input int n, input bit bad);
    logic [15:0] c;
    c = 16'h6363;
    repeat (3) @(negedge link_clk); // pause between frames
    for (int i = 0; i < n + 2; i++) begin
      @(negedge link_clk);
      rx_valid = 1'b1;
      rx_data = i < n ? f[i] : (i == n ? c[7:0] : c[15:8]) ^ {8{bad}};
      if (i < n) c = crc(c, f[i]);
    end
    @(negedge link_clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // released line does not keep its value
    rx_end = 1'b1;
    te = $time;
    @(negedge link_clk);
    rx_end = 1'b0;
  endtask
  // collect one reply; silence leaves rn at zero
  task automatic take(input int lim);
    bit fin;
    rn = 0;
    fin = 1'b0;
    for (int t = 0; t < lim && !fin; t++) begin
      @(negedge link_clk);
      tx_ready = !slow || t[0];
      // reply pins settled since the last rising edge; taken at the next
      if (tx_valid === 1'b1 && tx_ready) begin
        if (rn == 0) tf = $time;
        rnib = tx_nibble;
        rb[rn] = tx_data;
        rn++;
        fin = tx_last === 1'b1;
      end
      @(posedge link_clk);
    end
    @(negedge link_clk);
    tx_ready = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** bench/card_cmd_core_bench.sv ***
// bench: reader model drives frames, table rows then odd cases
// assumes the core is built with a short reply guard of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module card_cmd_core_bench;
  logic       clk = 1'b0, link_clk = 1'b0, reset = 1'b1;
  logic       rx_valid, rx_end, tx_ready, tx_valid, tx_nibble, tx_last;
  logic [7:0] rx_data, tx_data;
  logic       auth_valid = 1'b1;
  logic [3:0] auth_sector = 4'h1; // blocks 04h to 07h
  int         bad_count = 0, cmp_count = 0;
  logic [7:0] fr [18];
  typedef struct { logic [7:0] cmd, blk; logic [31:0] arg; bit nak; } row_s;
  row_s rows [19] = '{
    '{8'ha0,8'h04,32'h64,0}, '{8'h30,8'h04,32'h64,0},
    '{8'hc1,8'h04,32'h05,0}, '{8'h30,8'h04,32'h64,0},
    '{8'hb0,8'h04,32'h00,0}, '{8'h30,8'h04,32'h69,0},
    '{8'hc0,8'h04,32'h10,0}, '{8'hb0,8'h04,32'h00,0},
    '{8'h30,8'h04,32'h59,0}, '{8'hc0,8'h04,32'hfffffffe,0},
    '{8'hb0,8'h04,32'h00,0}, '{8'h30,8'h04,32'h5b,0},
    '{8'hc2,8'h04,32'h33,0}, '{8'ha0,8'h04,32'h11,0},
    '{8'hb0,8'h04,32'h00,0}, '{8'h30,8'h04,32'h5b,0},
    '{8'h30,8'h08,32'h00,1}, '{8'h30,8'h40,32'h00,1},
    '{8'h77,8'h04,32'h00,1}};
  always #2.5 clk = ~clk;
  initial #1.3 forever #6 link_clk = ~link_clk;
  card_cmd_core #(.GUARD_CYC(20)) DUT (.clk(clk), .reset(reset),
    .link_clk(link_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_nibble(tx_nibble), .tx_last(tx_last),
    .auth_valid(auth_valid), .auth_sector(auth_sector));
  card_reader r (.link_clk(link_clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_nibble(tx_nibble),
    .tx_last(tx_last));
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // sixteen data bytes: value little-endian, then byte index
  task automatic fill(input logic [31:0] v);
    for (int j = 0; j < 16; j++) fr[j] = j < 4 ? v[8*j+:8] : 8'(j);
  endtask
  // one exchange; e of ffh means no answer is expected
  task automatic xch(input int n, input bit bad, input logic [7:0] e);
    r.send(fr, n, bad);
    r.take(300);
    chk(r.rn, e == 8'hff ? 0 : 1);
    if (r.rn > 0) chk({r.rnib, r.rb[0]}, {1'b1, e});
    if (r.rn > 0) chk(r.tf - r.te >= 100, 1);
  endtask
  // read block 04h: value bytes, kept bytes, crc residue
  task automatic xrd(input logic [31:0] v);
    logic [15:0] c;
    c = 16'h6363;
    r.send(fr, 2, 0);
    r.take(300);
    chk(r.rn, 18);
    chk(r.rnib, 1'b0);
    chk({r.rb[3], r.rb[2], r.rb[1], r.rb[0]}, v);
    chk(r.rb[9], 8'h09);
    for (int j = 0; j < 18; j++) c = r.crc(c, r.rb[j]);
    chk(c, 16'h0000);
    chk(r.tf - r.te >= 100, 1);
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    final_report();
  end
  initial begin
    repeat (12) @(negedge clk);
    chk({tx_valid, tx_nibble, tx_last, tx_data}, 0);
    reset = 1'b0;
    repeat (8) @(negedge link_clk);
    foreach (rows[i]) begin
      r.slow = i[0];
      fr[0] = rows[i].cmd;
      fr[1] = rows[i].blk;
      if (rows[i].cmd == 8'h30 && !rows[i].nak) xrd(rows[i].arg);
      else begin
        xch(2, 0, rows[i].nak ? 8'h04 : 8'h0a);
        fill(rows[i].arg);
        if (!rows[i].nak && rows[i].cmd == 8'ha0) xch(16, 0, 8'h0a);
        if (!rows[i].nak && rows[i].cmd[7:4] == 4'hc) xch(4, 0, 8'hff);
      end
      $display("row %0d done", i);
    end
    fr[0] = 8'h30;
    fr[1] = 8'h04;
    xch(2, 1, 8'h04);
    fr[0] = 8'ha0;
    xch(2, 0, 8'h0a);
    fill(32'h77);
    xch(16, 1, 8'h04);
    fr[0] = 8'h30;
    fr[1] = 8'h04;
    xrd(32'h5b);
    xch(3, 0, 8'h04);
    @(negedge clk);
    auth_valid = 1'b0;
    xch(2, 0, 8'h04);
    $display("odd cases done");
    // reset in mid-run: pins clear, blocks kept, value register cleared
    @(negedge clk);
    reset = 1'b1;
    auth_valid = 1'b1;
    repeat (12) @(negedge clk);
    chk({tx_valid, tx_nibble, tx_last, tx_data}, 0);
    reset = 1'b0;
    repeat (8) @(negedge link_clk);
    fr[0] = 8'hc1;
    xch(2, 0, 8'h0a);
    fill(32'h05);
    xch(4, 1, 8'hff);
    fr[0] = 8'hb0;
    fr[1] = 8'h04;
    xch(2, 0, 8'h0a);
    fr[0] = 8'h30;
    xrd(32'h0);
    $display("reset case done");
    final_report();
  end
endmodule
`default_nettype wire
